// *** ncb_pkg.sv ***
/*
 * Constants, command codes and strobe timing for the host side flash bus controller.
 * Assumes a 100 MHz system clock and a single x8 multiplexed flash device on the pins.
 */
// ------------------------------------------------------------
// ------------------------------------------------------------
package ncb_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_RANDOM_OUT = 8'h05;
	localparam logic [7:0] CMD_RANDOM_OUT_CONFIRM = 8'hE0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h80;
	localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	// ------------------------------------------------------------
	// Operation selectors on the user port
	// ------------------------------------------------------------
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_RESET = 2'h3;
	// ------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------
	localparam int ADDR_CYCLES = 5;
	localparam int ROW_CYCLES = 3;
	localparam int PAGE_BYTES = 2112;
	localparam int CLOCK_NS = 10;
	localparam int STROBE_LOW_NS = 30;
	localparam int STROBE_HIGH_NS = 20;
	localparam int BUSY_WAIT_NS = 100;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int TIMER_W = 8;
	localparam int COL_W = 12;
	localparam int ROW_W = 17;
	localparam logic [COL_W-1:0] COL_LAST = COL_W'(PAGE_BYTES - 1);
endpackage : ncb_pkg

// *** ncb_buf_if.sv ***
/*
 * Valid/ready stream interface between the controller and its read buffer.
 * Assumes both ends share i_clock.
 */
interface ncb_buf_if;
	logic in_valid; // Producer has a byte
	logic in_ready; // Buffer can take it
	logic [7:0] in_data; // Byte from the pins
	logic out_valid; // Buffer holds a byte
	logic out_ready; // Consumer takes it
	logic [7:0] out_data; // Oldest byte
	modport fill(output in_valid, output in_data, input in_ready);
	modport buffer(input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport drain(input out_valid, input out_data, output out_ready);
endinterface : ncb_buf_if

// *** ncb_skid_buf.sv ***
/*
 * Two-entry FIFO for read data bytes.
 * Assumes a single clock and the valid/ready handshake of ncb_buf_if.
 */
module ncb_skid_buf #(
	parameter int DEPTH = 2
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	ncb_buf_if.buffer bif
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem; // Storage entries
		logic [1:0] count; // Occupancy, depth two
		logic rd; // Read slot
		logic wr; // Write slot
	} ncb_buf_st_t;
	ncb_buf_st_t st_q;
	ncb_buf_st_t st_d;
	logic push;
	logic pop;

	assign bif.in_ready = (st_q.count != 2'(DEPTH)); // Honest full
	assign bif.out_valid = (st_q.count != 2'h0); // Honest empty
	assign bif.out_data = st_q.mem[st_q.rd];
	assign push = bif.in_valid && bif.in_ready;
	assign pop = bif.out_valid && bif.out_ready;

	// Next state of pointers and storage
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr] = bif.in_data;
			st_d.wr = ~st_q.wr;
		end
		if (pop) begin
			st_d.rd = ~st_q.rd;
		end
		if (push && !pop) begin
			st_d.count = st_q.count + 2'h1;
		end else if (pop && !push) begin
			st_d.count = st_q.count - 2'h1;
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : ncb_skid_buf

// *** ncb_host.sv ***
/*
 * Host controller that drives the flash bus strobes for page read, program, erase and reset.
 * Assumes one flash device, a 100 MHz clock, and a user who holds request fields stable until accept.
 */
module ncb_host #(
	parameter int STROBE_LOW = ncb_pkg::STROBE_LOW_CYC,
	parameter int STROBE_HIGH = ncb_pkg::STROBE_HIGH_CYC,
	parameter int BUSY_WAIT = ncb_pkg::BUSY_WAIT_CYC
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire logic [1:0] i_req_op,
	input wire logic [ncb_pkg::COL_W-1:0] i_req_col,
	input wire logic [ncb_pkg::ROW_W-1:0] i_req_row,
	input wire logic [15:0] i_req_len,
	input wire logic i_wr_valid,
	input wire logic [7:0] i_wr_data,
	input wire logic i_rd_ready,
	input wire logic [7:0] i_io_in,
	input wire logic i_ready_busy_n,
	output logic o_req_ready,
	output logic o_wr_ready,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_done,
	output logic o_cle,
	output logic o_ale,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_read_strobe_n,
	output logic o_wp_n,
	output logic [7:0] o_io_out,
	output logic o_io_oe
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WAIT, S_BUSY, S_READ, S_DONE
	} ncb_state_t;

	typedef struct packed {
		ncb_state_t st;
		logic [1:0] op;
		logic [2:0] acnt; // Address byte index
		logic [39:0] addr; // Five address bytes, low first
		logic [15:0] len; // Bytes left
		logic [ncb_pkg::COL_W-1:0] col; // Current column
		logic [ncb_pkg::TIMER_W-1:0] tmr;
		logic phase; // Zero: strobe low, one: strobe high
		logic [1:0] rb_sync; // Busy pin synchroniser
		logic [1:0] io_sync_en;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
		logic req_ready;
		logic wr_ready;
		logic done;
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic re_n;
		logic [7:0] io;
		logic oe;
	} ncb_host_st_t;

	ncb_host_st_t s_q;
	ncb_host_st_t s_d;
	logic cap_valid;
	logic [7:0] cap_data;
	logic cap_ready;

	ncb_buf_if bif();
	assign bif.in_valid = cap_valid;
	assign bif.in_data = cap_data;
	assign cap_ready = bif.in_ready;
	assign bif.out_ready = i_rd_ready;

	ncb_skid_buf #(.DEPTH(2)) u_buf (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.bif(bif)
	);

	// Timer reload for the phase being entered
	function automatic logic [ncb_pkg::TIMER_W-1:0] phase_len(input logic ph);
		phase_len = ph ? ncb_pkg::TIMER_W'(STROBE_HIGH - 1) : ncb_pkg::TIMER_W'(STROBE_LOW - 1);
	endfunction : phase_len

	// Busy level after the synchroniser's second stage only
	logic dev_ready;
	assign dev_ready = s_q.rb_sync[1];
	// Read byte sampled one clock after the read strobe's rising edge, two stages late
	assign cap_valid = s_q.io_sync_en[1];
	assign cap_data = s_q.io_s2;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		logic tick;
		logic strobe_end;
		s_d = s_q;
		tick = (s_q.tmr == '0);
		strobe_end = tick && s_q.phase;
		s_d.rb_sync = {s_q.rb_sync[0], i_ready_busy_n};
		s_d.io_s1 = i_io_in;
		s_d.io_s2 = s_q.io_s1;
		s_d.io_sync_en = {s_q.io_sync_en[0], 1'b0};
		s_d.done = 1'b0;
		s_d.req_ready = 1'b0;
		s_d.wr_ready = 1'b0;
		if (!tick) begin
			s_d.tmr = s_q.tmr - 1'b1;
		end
		case (s_q.st)
			S_IDLE: begin
				s_d.req_ready = 1'b1;
				s_d.ce_n = 1'b1;
				if (i_req_valid && s_q.req_ready) begin
					s_d.req_ready = 1'b0;
					s_d.op = i_req_op;
					s_d.len = i_req_len;
					s_d.col = i_req_col;
					s_d.addr = {7'h00, i_req_row, 4'h0, i_req_col};
					s_d.acnt = '0;
					s_d.ce_n = 1'b0;
					s_d.st = S_CMD1;
					s_d.phase = 1'b0;
					s_d.tmr = phase_len(1'b0);
				end
			end
			S_CMD1: begin
				// First command byte with CLE high, ALE low
				// Latch held through the high phase so it outlasts the write strobe rise
				s_d.cle = 1'b1;
				s_d.ale = 1'b0;
				s_d.oe = 1'b1;
				s_d.we_n = s_q.phase;
				// Defined setup codes only; no copy-back or random column commands are issued
				case (s_q.op)
					ncb_pkg::OP_READ: s_d.io = ncb_pkg::CMD_READ_SETUP;
					ncb_pkg::OP_PROGRAM: s_d.io = ncb_pkg::CMD_PROGRAM_SETUP;
					ncb_pkg::OP_ERASE: s_d.io = ncb_pkg::CMD_ERASE_SETUP;
					default: s_d.io = ncb_pkg::CMD_RESET; // reset accepted while busy
				endcase
				if (tick) begin
					s_d.phase = ~s_q.phase;
					s_d.tmr = phase_len(~s_q.phase);
					if (strobe_end) begin
						s_d.cle = 1'b0;
						if (s_q.op == ncb_pkg::OP_RESET) begin
							s_d.st = S_WAIT;
							// Only the reset waits for busy here; address bytes keep the strobe timing
							s_d.tmr = ncb_pkg::TIMER_W'(BUSY_WAIT - 1);
						end else begin
							s_d.st = S_ADDR;
							s_d.acnt = (s_q.op == ncb_pkg::OP_ERASE) ? 3'(ncb_pkg::ADDR_CYCLES
								- ncb_pkg::ROW_CYCLES) : 3'h0;
						end
					end
				end
			end
			S_ADDR: begin
				// Address bytes with ALE high, latched on WE rise
				s_d.ale = 1'b1;
				s_d.oe = 1'b1;
				s_d.we_n = s_q.phase;
				s_d.io = s_q.addr[8*s_q.acnt +: 8];
				if (tick) begin
					s_d.phase = ~s_q.phase;
					s_d.tmr = phase_len(~s_q.phase);
					if (strobe_end) begin
						s_d.acnt = s_q.acnt + 3'h1;
						if (s_q.acnt == 3'(ncb_pkg::ADDR_CYCLES - 1)) begin
							s_d.ale = 1'b0;
							s_d.st = (s_q.op == ncb_pkg::OP_PROGRAM) ? S_DATA : S_CMD2;
						end
					end
				end
			end
			S_DATA: begin
				// Program data: both latches low, one byte per WE rise
				// Ready only while waiting for a byte, so every handshake is a real take
				s_d.oe = 1'b1;
				if (s_q.len == '0) begin
					s_d.st = S_CMD2;
					s_d.tmr = phase_len(1'b0); // Full low phase for the confirm strobe
				end else if (!s_q.phase && s_q.we_n) begin
					if (i_wr_valid && s_q.wr_ready) begin
						s_d.io = i_wr_data;
						s_d.we_n = 1'b0;
						s_d.tmr = phase_len(1'b0);
					end else begin
						s_d.wr_ready = 1'b1;
					end
				end else if (tick) begin
					s_d.phase = ~s_q.phase;
					s_d.tmr = phase_len(~s_q.phase);
					s_d.we_n = 1'b1;
					if (s_q.phase) begin
						s_d.len = s_q.len - 16'h1;
					end
				end
			end
			S_CMD2: begin
				// Confirm code; the device refuses program/erase if protect is low
				s_d.cle = 1'b1;
				s_d.oe = 1'b1;
				s_d.we_n = s_q.phase;
				case (s_q.op)
					ncb_pkg::OP_READ: s_d.io = ncb_pkg::CMD_READ_CONFIRM;
					ncb_pkg::OP_PROGRAM: s_d.io = ncb_pkg::CMD_PROGRAM_CONFIRM;
					default: s_d.io = ncb_pkg::CMD_ERASE_CONFIRM;
				endcase
				if (tick) begin
					s_d.phase = ~s_q.phase;
					s_d.tmr = phase_len(~s_q.phase);
					if (strobe_end) begin
						s_d.cle = 1'b0;
						s_d.st = S_WAIT;
						s_d.tmr = ncb_pkg::TIMER_W'(BUSY_WAIT - 1);
					end
				end
			end
			S_WAIT: begin
				// Give the device time to pull busy low
				s_d.oe = 1'b0;
				if (tick) begin
					s_d.st = S_BUSY;
				end
			end
			S_BUSY: begin
				// Transfer in progress while busy is low
				if (dev_ready) begin
					s_d.st = (s_q.op == ncb_pkg::OP_READ && s_q.len != '0) ? S_READ : S_DONE;
					s_d.phase = 1'b0;
					s_d.tmr = phase_len(1'b0);
				end
			end
			S_READ: begin
				// Sequential output, one byte per read strobe pulse; paused while the buffer is full
				if (s_q.len == '0 || s_q.col > ncb_pkg::COL_LAST) begin
					s_d.st = S_DONE;
				end else if (s_q.phase || cap_ready) begin
					s_d.re_n = s_q.phase;
					if (tick) begin
						s_d.phase = ~s_q.phase;
						s_d.tmr = phase_len(~s_q.phase);
						if (strobe_end) begin
							s_d.io_sync_en[0] = 1'b1;
							s_d.len = s_q.len - 16'h1;
							s_d.col = s_q.col + 1'b1;
						end
					end
				end
			end
			default: begin
				// S_DONE
				s_d.done = 1'b1;
				s_d.ce_n = 1'b1;
				s_d.re_n = 1'b1;
				s_d.st = S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '0;
			s_q.st <= S_IDLE;
			s_q.ce_n <= 1'b1;
			s_q.we_n <= 1'b1;
			s_q.re_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_req_ready = s_q.req_ready;
	assign o_wr_ready = s_q.wr_ready;
	assign o_rd_valid = bif.out_valid;
	assign o_rd_data = bif.out_data;
	assign o_done = s_q.done;
	assign o_cle = s_q.cle;
	assign o_ale = s_q.ale;
	assign o_ce_n = s_q.ce_n;
	assign o_we_n = s_q.we_n;
	assign o_read_strobe_n = s_q.re_n;
	assign o_wp_n = 1'b1; // protect released so program and erase proceed
	assign o_io_out = s_q.io;
	assign o_io_oe = s_q.oe;
endmodule : ncb_host

// *** ncb_host_properties.sv ***
/* Pin-level checks on the host flash bus controller.
   Assumes a bind onto ncb_host with strobes of 3 low and 2 high cycles. */
module ncb_host_properties (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire logic i_ready_busy_n,
	input wire logic o_req_ready,
	input wire logic o_done,
	input wire logic o_cle,
	input wire logic o_ale,
	input wire logic o_ce_n,
	input wire logic o_we_n,
	input wire logic o_read_strobe_n,
	input wire logic o_wp_n,
	input wire logic [7:0] o_io_out,
	input wire logic o_io_oe
);
	// ----------------------------------------
	// One clock domain
	// ----------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	// ----------------------------------------
	// Strobe and latch relations
	// ----------------------------------------
	cmd_not_addr_a: assert property (o_cle |-> !o_ale)
		else $error("command and address latch both high");
	latch_hold_a: assert property ($rose(o_we_n) |-> $stable(o_io_out) && o_io_oe)
		else $error("bus byte moved at write strobe rise");
	we_low_len_a: assert property ($fell(o_we_n) |-> (!o_we_n)[*3] ##1 o_we_n)
		else $error("write strobe low phase not three cycles");
	we_select_a: assert property (!o_we_n |-> !o_ce_n && o_read_strobe_n && o_io_oe)
		else $error("write strobe without select or bus drive");
	re_phase_a: assert property (!o_read_strobe_n |-> o_we_n && !o_cle && !o_ale && !o_ce_n && !o_io_oe)
		else $error("read strobe outside data output phase");
	// ----------------------------------------
	// Busy and sequencing
	// ----------------------------------------
	busy_quiet_a: assert property ((!i_ready_busy_n)[*4] |-> o_read_strobe_n && o_we_n)
		else $error("strobe while device busy");
	done_ready_a: assert property (o_done |-> i_ready_busy_n && $past(i_ready_busy_n, 2))
		else $error("done before busy released");
	accept_cmd_a: assert property (i_req_valid && o_req_ready |=> !o_req_ready ##[0:20] (o_cle && !o_we_n))
		else $error("no command cycle after accepted request");
	wp_high_a: assert property (o_wp_n)
		else $error("write protect driven low");
endmodule : ncb_host_properties

bind ncb_host ncb_host_properties u_ncb_host_properties (.i_clock(i_clock), .i_nrst(i_nrst),
	.i_req_valid(i_req_valid), .i_ready_busy_n(i_ready_busy_n), .o_req_ready(o_req_ready),
	.o_done(o_done), .o_cle(o_cle), .o_ale(o_ale), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
	.o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .o_io_out(o_io_out), .o_io_oe(o_io_oe));

// *** ncb_flash_model.sv ***
/* Behavioural x8 flash device holding a single page shared by all rows.
   Assumes the host drives strobes; busy is driven both high and low by the model. */
module ncb_flash_model #(
	parameter int ARRAY_NS = 500
) (
	input wire logic i_cle,
	input wire logic i_ale,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_read_strobe_n,
	input wire logic i_wp_n,
	input wire logic [7:0] i_io,
	output logic [7:0] o_io,
	output logic o_ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] arr [ncb_pkg::PAGE_BYTES]; // Array page
	logic [7:0] dreg [ncb_pkg::PAGE_BYTES]; // Data register
	logic [7:0] cmd_q = 8'h00; // Power-on read setup
	logic [7:0] abuf [5]; // Address bytes
	logic [11:0] col_q = 12'h000; // Column pointer
	logic [16:0] row_q; // Row address
	logic rd_mode = 1'b0; // Status, not data, on reads
	int n_addr = 0;
	event start_e;
	// Only defined codes reach the command register
	function automatic logic known(input logic [7:0] c);
		return c inside {8'h00, 8'h30, 8'h35, 8'h31, 8'h3F, 8'h90, 8'h70, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h60,
			8'hD0, 8'h85, 8'h05, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h78, 8'h06, 8'h11, 8'h81, 8'hD1};
	endfunction : known
	initial begin
		o_ready_busy_n = 1'b1;
		o_io = 8'h00;
		foreach (abuf[i]) abuf[i] = 8'h00;
		foreach (arr[i]) arr[i] = 8'(i) ^ 8'hA5;
	end
	// Latch cycles on write strobe rise
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_cle && !i_ale && known(i_io) && (o_ready_busy_n || i_io inside {8'h70, 8'h78, 8'hFF})) begin
			cmd_q = i_io;
			n_addr = 0;
			if (i_io == 8'h70) rd_mode = 1'b0;
			else if (i_io inside {8'h00, 8'h30}) rd_mode = 1'b1;
			if (i_io == 8'h80) foreach (dreg[i]) dreg[i] = 8'hFF;
			if (i_io inside {8'h30, 8'h10, 8'hD0, 8'hFF}) ->start_e;
		end else if (!i_ce_n && i_ale && !i_cle && n_addr < ((cmd_q == 8'h60) ? 3 : 5)) begin
			abuf[n_addr + ((cmd_q == 8'h60) ? 2 : 0)] = i_io; // Erase sends row only
			n_addr++;
			col_q = {abuf[1][3:0], abuf[0]};
			row_q = {abuf[4][0], abuf[3], abuf[2]};
		end else if (!i_ce_n && !i_cle && !i_ale && i_read_strobe_n && cmd_q == 8'h80) begin
			dreg[col_q] = i_io;
			col_q++;
		end
	end
	// Array operation while busy is held low
	always begin
		@(start_e);
		#10 o_ready_busy_n = 1'b0;
		#(ARRAY_NS);
		case (cmd_q)
			8'h30: foreach (dreg[i]) dreg[i] = arr[i];
			8'h10: if (i_wp_n) foreach (arr[i]) arr[i] &= dreg[i];
			8'hD0: if (i_wp_n) foreach (arr[i]) arr[i] = 8'hFF;
			default: begin
				cmd_q = 8'h00;
				rd_mode = 1'b0;
			end
		endcase
		o_ready_busy_n = 1'b1;
	end
	// Output byte after read strobe falls
	always @(negedge i_read_strobe_n) if (!i_ce_n && o_ready_busy_n)
		#5 o_io = rd_mode ? dreg[col_q] : {i_wp_n, o_ready_busy_n, 6'h00};
	// Advance column; hold time then garbage
	always @(posedge i_read_strobe_n) if (!i_ce_n) begin
		if (rd_mode && col_q < 12'(ncb_pkg::PAGE_BYTES - 1)) col_q++;
		#15 o_io = ~o_io;
	end
endmodule : ncb_flash_model

// *** ncb_host_tb_top.sv ***
/* Self-checking bench: ncb_host against the behavioural flash model.
   Assumes default strobe timing and a model keeping one page for all rows. */
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ncb_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [16:0] ROW = 17'h1ABCD; // Top bit exercises fifth cycle
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic i_req_valid = 1'b0;
	logic [1:0] i_req_op = 2'h0;
	logic [11:0] i_req_col = 12'h000;
	logic [15:0] i_req_len = 16'h0000;
	logic i_wr_valid = 1'b0;
	logic [7:0] i_wr_data = 8'h00;
	logic i_rd_ready = 1'b0;
	logic o_req_ready, o_wr_ready, o_rd_valid, o_done, o_cle, o_ale, o_ce_n, o_we_n, o_re_n, o_wp_n, o_io_oe, rb_n;
	logic [7:0] o_rd_data, o_io_out, flash_io;
	logic [7:0] mirror [ncb_pkg::PAGE_BYTES]; // Expected page contents
	int n_errors = 0;
	int samples_checked = 0;
	always #5 i_clock = ~i_clock;
	ncb_host u_ncb_host (.i_clock(i_clock), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
		.i_req_col(i_req_col), .i_req_row(ROW), .i_req_len(i_req_len), .i_wr_valid(i_wr_valid),
		.i_wr_data(i_wr_data), .i_rd_ready(i_rd_ready), .i_io_in(o_io_oe ? o_io_out : flash_io),
		.i_ready_busy_n(rb_n), .o_req_ready(o_req_ready), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
		.o_rd_data(o_rd_data), .o_done(o_done), .o_cle(o_cle), .o_ale(o_ale), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
		.o_read_strobe_n(o_re_n), .o_wp_n(o_wp_n), .o_io_out(o_io_out),
		.o_io_oe(o_io_oe));
	ncb_flash_model u_flash (.i_cle(o_cle), .i_ale(o_ale), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
		.i_read_strobe_n(o_re_n), .i_wp_n(o_wp_n), .i_io(o_io_out), .o_io(flash_io), .o_ready_busy_n(rb_n));
	// Verdict and end of run
	task automatic wrap_up;
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Hold a request until taken
	task automatic issue(input logic [1:0] op, input logic [11:0] col, input logic [15:0] len);
		int k;
		k = 0;
		i_req_op = op;
		i_req_col = col;
		i_req_len = len;
		i_req_valid = 1'b1;
		do begin
			@(posedge i_clock);
			k++;
		end while (o_req_ready !== 1'b1 && k < 200);
		if (k >= 200) begin n_errors++; wrap_up(); end
		#1 i_req_valid = 1'b0;
	endtask : issue
	// Bounded wait for completion pulse
	task automatic wait_done;
		int k;
		for (k = 0; k < 5000 && o_done !== 1'b1; k++) @(posedge i_clock);
		if (k >= 5000) begin n_errors++; wrap_up(); end
		#1;
	endtask : wait_done
	// Page read with a slow consumer so the buffer fills
	task automatic t_read(input logic [11:0] col, input int len);
		int got, k;
		logic seen;
		got = 0;
		seen = 1'b0;
		issue(ncb_pkg::OP_READ, col, 16'(len));
		for (k = 0; k < 8000 && !(seen && got == len); k++) begin
			@(posedge i_clock);
			if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1) begin
				`CHK(o_rd_data, mirror[col + got])
				got++;
			end
			if (o_done === 1'b1) seen = 1'b1;
			#1 i_rd_ready = (k % 16 == 15);
		end
		if (k >= 8000) begin n_errors++; wrap_up(); end
		i_rd_ready = 1'b0;
		repeat (4) @(posedge i_clock);
		`CHK(o_rd_valid, 1'b0)
		`CHK(u_flash.row_q, ROW)
		#1;
	endtask : t_read
	// Program three bytes at a column
	task automatic t_prog(input logic [11:0] col, input logic [7:0] d0);
		int idx, k;
		idx = 0;
		issue(ncb_pkg::OP_PROGRAM, col, 16'h0003);
		i_wr_valid = 1'b1;
		i_wr_data = d0;
		for (k = 0; k < 5000 && o_done !== 1'b1; k++) begin
			@(posedge i_clock);
			if (i_wr_valid && o_wr_ready === 1'b1) idx++;
			#1 i_wr_valid = (idx < 3);
			i_wr_data = d0 + 8'(idx);
		end
		if (k >= 5000) begin n_errors++; wrap_up(); end
		for (idx = 0; idx < 3; idx++) mirror[col + idx] &= d0 + 8'(idx);
		`CHK(u_flash.row_q, ROW)
		`CHK(u_flash.arr[col + 1], mirror[col + 1])
	endtask : t_prog
	// Erase sends row only; first two bytes of the page read back blank
	task automatic t_erase;
		issue(ncb_pkg::OP_ERASE, 12'h000, 16'h0000);
		wait_done();
		foreach (mirror[i]) mirror[i] = 8'hFF;
		`CHK(u_flash.row_q, ROW)
		t_read(12'h000, 2);
	endtask : t_erase
	// Reset command returns device to read setup
	task automatic t_reset;
		issue(ncb_pkg::OP_RESET, 12'h000, 16'h0000);
		wait_done();
		`CHK(u_flash.cmd_q, ncb_pkg::CMD_READ_SETUP)
	endtask : t_reset
	// Main sequence
	initial begin
		foreach (mirror[i]) mirror[i] = 8'(i) ^ 8'hA5;
		repeat (10) @(posedge i_clock);
		`CHK({o_ce_n, o_we_n, o_re_n, o_cle, o_ale, o_io_oe}, 6'h38)
		`CHK(u_flash.cmd_q, ncb_pkg::CMD_READ_SETUP)
		#1 i_nrst = 1'b1;
		repeat (3) @(posedge i_clock);
		#1;
		t_read(12'h000, 6);
		t_read(ncb_pkg::COL_LAST - 12'h001, 2);
		t_prog(12'h008, 8'h5C);
		t_read(12'h007, 5);
		t_erase();
		t_reset();
		wrap_up();
	end
endmodule : ncb_host_tb_top
